//--- verilog/ns_ident_pkg.sv
package ns_ident_pkg;

    // bus and field widths
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 32;
    localparam int unsigned IDX_W   = 8;
    localparam int unsigned FIELD_W = 16;
    localparam int unsigned WIDE_W  = 128;

    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_NS_NORMAL_ATOMIC_UNIT        = 8'h22;
    localparam logic [7:0] IDX_NS_POWERFAIL_ATOMIC_UNIT     = 8'h24;
    localparam logic [7:0] IDX_NS_COMPARE_WRITE_ATOMIC_UNIT = 8'h26;
    localparam logic [7:0] IDX_NS_NORMAL_BOUNDARY_SIZE      = 8'h28;
    localparam logic [7:0] IDX_NS_BOUNDARY_START_OFFSET     = 8'h2A;
    localparam logic [7:0] IDX_NS_POWERFAIL_BOUNDARY_SIZE   = 8'h2C;
    localparam logic [7:0] IDX_RESERVED_A                   = 8'h2E;
    localparam logic [7:0] IDX_NS_ALLOCATED_CAPACITY        = 8'h30;
    localparam logic [7:0] IDX_RESERVED_B                   = 8'h40;
    localparam logic [7:0] IDX_NS_GLOBAL_UNIQUE_ID          = 8'h68;

    // block-local control and status words
    localparam logic [7:0] IDX_PROV_CTRL   = 8'h80;
    localparam logic [7:0] IDX_ID_ORG      = 8'h81;
    localparam logic [7:0] IDX_PROV_STATUS = 8'h82;

    // provisioning control fields
    localparam int unsigned CTRL_UNLOCK_BIT = 0;
    localparam int unsigned CTRL_LOCK_BIT   = 1;
    localparam int unsigned CTRL_DELETE_BIT = 2;

    // status fields
    localparam int unsigned STAT_ID_LOCKED_BIT   = 0;
    localparam int unsigned STAT_MGMT_BIT        = 1;
    localparam int unsigned STAT_CAP_NONZERO_BIT = 2;
    localparam int unsigned STAT_CAP_MISSING_BIT = 3;
    localparam int unsigned STAT_W               = 4;

    // organization identifier position inside the unique id
    localparam int unsigned ID_ORG_LSB = 64;
    localparam int unsigned ID_ORG_W   = 24;

    // reset values, fillers and bus codes
    localparam logic [15:0]  FIELD_RESET = 16'h0000;
    localparam logic [127:0] WIDE_RESET  = 128'h0;
    localparam logic [31:0]  WORD_ZERO   = 32'h0000_0000;
    localparam logic [15:0]  HALF_ZERO   = 16'h0000;
    localparam logic [7:0]   ORG_PAD     = 8'h00;
    localparam logic [27:0]  STAT_PAD    = 28'h0000000;
    localparam logic [1:0]   HTRANS_NSEQ = 2'h2;
    localparam logic         HRESP_OKAY  = 1'b0;

endpackage : ns_ident_pkg

//--- verilog/atomic_unit_report.sv
module atomic_unit_report
(
    input  wire logic                               ref_clk,
    input  wire logic                               rst,
    input  wire logic                               ce,
    input  wire logic [ns_ident_pkg::FIELD_W-1:0]   cfg,
    input  wire logic [ns_ident_pkg::FIELD_W-1:0]   ctrl_unit,
    output logic      [ns_ident_pkg::FIELD_W-1:0]   rep_q
);

    import ns_ident_pkg::*;

    logic [FIELD_W-1:0] rep_d;
    wire                same_as_ctrl;

    // R01 - zero when matching
    assign same_as_ctrl = (cfg == ctrl_unit);
    assign rep_d        = same_as_ctrl ? FIELD_RESET : cfg;

    // reported value register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rep_q <= FIELD_RESET;
        end else if (ce) begin
            rep_q <= rep_d;
        end
    end

    property p_match_zero;
        @(posedge ref_clk) disable iff (rst)
        (ce && cfg == ctrl_unit) |=> (rep_q == FIELD_RESET);
    endproperty
    a_match_zero: assert property (p_match_zero) // R01
        else $error("matching atomic unit not reported as zero");

endmodule // atomic_unit_report

//--- verilog/ns_ident_regs.sv
// Behaviour
// R01 - normal atomic unit zero when equals controller
// R02 - powerfail atomic unit zero when equals controller
// R03 - compare-write unit zero when equals controller
// R04 - normal boundary size, zero means none
// R05 - no atomicity across normal boundary
// R06 - powerfail boundary size, zero means none
// R07 - no read-data promise across powerfail boundary
// R08 - offset zero when both sizes zero
// R09 - offset never exceeds either boundary size
// R10 - capacity is sixteen-byte byte count
// R11 - capacity populated when management supported (not enforced; status bit 3 flags it missing)
// R12 - capacity independent of block count product
// R13 - unique id fixed across reset, format
// R14 - organization id in bytes 114:112
// R15 - reserved positions read as zero
//
// The AHB-Lite slave port was left to the implementer.
module ns_ident_regs
(
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    input  wire logic                              por_rst,
    input  wire logic                              ce,
    input  wire logic                              hsel,
    input  wire logic [ns_ident_pkg::ADDR_W-1:0]   haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [ns_ident_pkg::DATA_W-1:0]   hwdata,
    input  wire logic                              hready,
    output logic      [ns_ident_pkg::DATA_W-1:0]   hrdata_q,
    output logic                                   hreadyout_q,
    output logic                                   hresp_q,
    input  wire logic [ns_ident_pkg::FIELD_W-1:0]  ctrl_normal_atomic_unit,
    input  wire logic [ns_ident_pkg::FIELD_W-1:0]  ctrl_powerfail_atomic_unit,
    input  wire logic [ns_ident_pkg::FIELD_W-1:0]  ctrl_compare_write_atomic_unit,
    input  wire logic                              ns_mgmt_supported
);
    import ns_ident_pkg::*;

    // bus phase state
    logic               wr_pend_q;
    logic               rd_pend_q;
    logic [IDX_W-1:0]   idx_q;

    // stored configuration
    logic [FIELD_W-1:0] norm_unit_q;
    logic [FIELD_W-1:0] pf_unit_q;
    logic [FIELD_W-1:0] cw_unit_q;
    logic [FIELD_W-1:0] norm_bsize_q;
    logic [FIELD_W-1:0] bnd_off_q;
    logic [FIELD_W-1:0] pf_bsize_q;
    logic [WIDE_W-1:0]  cap_q;
    logic [WIDE_W-1:0]  id_q;
    logic               unlock_q;
    logic               id_locked_q;

    // reported values
    logic [FIELD_W-1:0] norm_unit_rep;
    logic [FIELD_W-1:0] pf_unit_rep;
    logic [FIELD_W-1:0] cw_unit_rep;
    logic [FIELD_W-1:0] off_rep_q;
    logic [FIELD_W-1:0] off_rep_d;

    // address phase qualification
    wire                addr_ok;
    wire [IDX_W-1:0]    widx;
    wire                wr_fire;
    wire                wr_cfg;
    wire                wr_id;
    assign addr_ok = hsel && htrans[1] && hready;
    assign widx    = haddr[IDX_W+1:2];
    assign wr_fire = wr_pend_q && hready;
    assign wr_cfg  = wr_fire && unlock_q;

    // index decode for the pending transfer
    wire hit_norm_unit;
    wire hit_pf_unit;
    wire hit_cw_unit;
    wire hit_norm_bsize;
    wire hit_bnd_off;
    wire hit_pf_bsize;
    wire hit_cap;
    wire hit_id;
    wire hit_ctrl;
    wire hit_org;
    wire hit_stat;
    wire hit_rsvd;
    assign hit_norm_unit  = (idx_q == IDX_NS_NORMAL_ATOMIC_UNIT);
    assign hit_pf_unit    = (idx_q == IDX_NS_POWERFAIL_ATOMIC_UNIT);
    assign hit_cw_unit    = (idx_q == IDX_NS_COMPARE_WRITE_ATOMIC_UNIT);
    assign hit_norm_bsize = (idx_q == IDX_NS_NORMAL_BOUNDARY_SIZE);
    assign hit_bnd_off    = (idx_q == IDX_NS_BOUNDARY_START_OFFSET);
    assign hit_pf_bsize   = (idx_q == IDX_NS_POWERFAIL_BOUNDARY_SIZE);
    assign hit_cap        = (idx_q[7:2] == IDX_NS_ALLOCATED_CAPACITY[7:2]);
    assign hit_id         = (idx_q[7:2] == IDX_NS_GLOBAL_UNIQUE_ID[7:2]);
    assign hit_ctrl       = (idx_q == IDX_PROV_CTRL);
    assign hit_org        = (idx_q == IDX_ID_ORG);
    assign hit_stat       = (idx_q == IDX_PROV_STATUS);

    // R15 - unmapped reads zero
    assign hit_rsvd = !(hit_norm_unit || hit_pf_unit || hit_cw_unit || hit_norm_bsize
                     || hit_bnd_off || hit_pf_bsize || hit_cap || hit_id
                     || hit_ctrl || hit_org || hit_stat);

    // provisioning commands
    wire ctrl_fire;
    wire lock_fire;
    wire del_fire;
    assign ctrl_fire = wr_fire && hit_ctrl;
    assign lock_fire = ctrl_fire && hwdata[CTRL_LOCK_BIT];
    assign del_fire  = ctrl_fire && hwdata[CTRL_DELETE_BIT];
    assign wr_id     = wr_cfg && hit_id && !id_locked_q;

    // wide field chunk select
    wire [6:0]        chunk_lsb;
    wire [DATA_W-1:0] cap_word;
    wire [DATA_W-1:0] id_word;
    assign chunk_lsb = {idx_q[1:0], 5'h00};
    assign cap_word  = cap_q[chunk_lsb +: DATA_W];
    assign id_word   = id_q[chunk_lsb +: DATA_W];

    // status word
    wire               cap_nonzero;
    wire [STAT_W-1:0]  stat_bits;
    assign cap_nonzero = (cap_q != WIDE_RESET);

    // R11 - flag missing capacity
    assign stat_bits[STAT_ID_LOCKED_BIT]   = id_locked_q;
    assign stat_bits[STAT_MGMT_BIT]        = ns_mgmt_supported;
    assign stat_bits[STAT_CAP_NONZERO_BIT] = cap_nonzero;
    assign stat_bits[STAT_CAP_MISSING_BIT] = ns_mgmt_supported && !cap_nonzero;

    // read data selection
    // R14 - org id readable apart
    wire [DATA_W-1:0] rd_word;
    assign rd_word = hit_norm_unit  ? {HALF_ZERO, norm_unit_rep} :
                     hit_pf_unit    ? {HALF_ZERO, pf_unit_rep}   :
                     hit_cw_unit    ? {HALF_ZERO, cw_unit_rep}   :
                     hit_norm_bsize ? {HALF_ZERO, norm_bsize_q}  :
                     hit_bnd_off    ? {HALF_ZERO, off_rep_q}     :
                     hit_pf_bsize   ? {HALF_ZERO, pf_bsize_q}    :
                     hit_cap        ? cap_word                   :
                     hit_id         ? id_word                    :
                     hit_ctrl       ? {29'h00000000, id_locked_q, 1'b0, unlock_q} :
                     hit_org        ? {ORG_PAD, id_q[ID_ORG_LSB +: ID_ORG_W]} :
                     hit_stat       ? {STAT_PAD, stat_bits}      :
                     WORD_ZERO;

    // address phase capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q     <= '0;
        end else if (ce) begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            if (addr_ok) begin
                idx_q <= widx;
            end
        end
    end

    // one wait state on reads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= HRESP_OKAY;
        end else if (ce) begin
            hreadyout_q <= !(addr_ok && !hwrite);
            hresp_q     <= HRESP_OKAY;
        end
    end

    // read data register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata_q <= WORD_ZERO;
        end else if (ce && rd_pend_q) begin
            hrdata_q <= rd_word;
        end
    end

    // provisioning unlock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            unlock_q <= 1'b0;
        end else if (ce && ctrl_fire) begin
            unlock_q <= hwdata[CTRL_UNLOCK_BIT];
        end
    end

    // atomic unit fields
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            norm_unit_q <= FIELD_RESET;
            pf_unit_q   <= FIELD_RESET;
            cw_unit_q   <= FIELD_RESET;
        end else if (ce && wr_cfg) begin
            if (hit_norm_unit) norm_unit_q <= hwdata[FIELD_W-1:0];
            if (hit_pf_unit)   pf_unit_q   <= hwdata[FIELD_W-1:0];
            if (hit_cw_unit)   cw_unit_q   <= hwdata[FIELD_W-1:0];
        end
    end

    // R04 - normal boundary size stored
    // R06 - powerfail boundary size stored
    // R05 - no boundary atomicity tracking
    // R07 - no post-crossing data tracking
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            norm_bsize_q <= FIELD_RESET;
            bnd_off_q    <= FIELD_RESET;
            pf_bsize_q   <= FIELD_RESET;
        end else if (ce && wr_cfg) begin
            if (hit_norm_bsize) norm_bsize_q <= hwdata[FIELD_W-1:0];
            if (hit_bnd_off)    bnd_off_q    <= hwdata[FIELD_W-1:0];
            if (hit_pf_bsize)   pf_bsize_q   <= hwdata[FIELD_W-1:0];
        end
    end

    // R10 - byte count chunks
    // R12 - stored as given, not derived
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_q <= WIDE_RESET;
        end else if (ce && wr_cfg && hit_cap) begin
            cap_q[chunk_lsb +: DATA_W] <= hwdata;
        end
    end

    // R13 - id kept over controller reset
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            id_q        <= WIDE_RESET;
            id_locked_q <= 1'b0;
        end else if (ce) begin
            if (lock_fire) begin
                id_locked_q <= 1'b1;
            end else if (del_fire) begin
                id_locked_q <= 1'b0;
            end
            if (del_fire && !lock_fire) begin
                id_q <= WIDE_RESET;
            end else if (wr_id) begin
                id_q[chunk_lsb +: DATA_W] <= hwdata;
            end
        end
    end

    // R01 - normal unit report
    atomic_unit_report u_normal (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .cfg       (norm_unit_q),
        .ctrl_unit (ctrl_normal_atomic_unit),
        .rep_q     (norm_unit_rep)
    );

    // R02 - powerfail unit report
    atomic_unit_report u_powerfail (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .cfg       (pf_unit_q),
        .ctrl_unit (ctrl_powerfail_atomic_unit),
        .rep_q     (pf_unit_rep)
    );

    // R03 - compare-write unit report
    atomic_unit_report u_compare (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .cfg       (cw_unit_q),
        .ctrl_unit (ctrl_compare_write_atomic_unit),
        .rep_q     (cw_unit_rep)
    );

    // boundary offset clamp
    wire [FIELD_W-1:0] size_min;
    wire               no_bounds;
    assign size_min  = (norm_bsize_q < pf_bsize_q) ? norm_bsize_q : pf_bsize_q;
    assign no_bounds = (norm_bsize_q == FIELD_RESET) && (pf_bsize_q == FIELD_RESET);

    // R08 - zero without boundaries
    // R09 - clamp to smaller size
    assign off_rep_d = no_bounds ? FIELD_RESET :
                       (bnd_off_q > size_min) ? size_min : bnd_off_q;

    // reported offset register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            off_rep_q <= FIELD_RESET;
        end else if (ce) begin
            off_rep_q <= off_rep_d;
        end
    end

    property p_pf_pass;
        @(posedge ref_clk) disable iff (rst)
        (ce && pf_unit_q != ctrl_powerfail_atomic_unit)
            |=> (pf_unit_rep == $past(pf_unit_q));
    endproperty
    a_pf_pass: assert property (p_pf_pass) // R02
        else $error("powerfail unit not passed through");

    property p_cw_zero;
        @(posedge ref_clk) disable iff (rst)
        (ce && cw_unit_q == ctrl_compare_write_atomic_unit)
            |=> (cw_unit_rep == FIELD_RESET);
    endproperty
    a_cw_zero: assert property (p_cw_zero) // R03
        else $error("matching compare-write unit not zero");

    property p_off_zero;
        @(posedge ref_clk) disable iff (rst)
        (ce && norm_bsize_q == FIELD_RESET && pf_bsize_q == FIELD_RESET)
            |=> (off_rep_q == FIELD_RESET);
    endproperty
    a_off_zero: assert property (p_off_zero) // R08
        else $error("offset nonzero with no boundaries");

    property p_off_bound;
        @(posedge ref_clk) disable iff (rst)
        ce |=> (off_rep_q <= $past(norm_bsize_q)) && (off_rep_q <= $past(pf_bsize_q));
    endproperty
    a_off_bound: assert property (p_off_bound) // R09
        else $error("offset above a boundary size");

    property p_cap_write;
        @(posedge ref_clk) disable iff (rst)
        (ce && wr_cfg && hit_cap && idx_q[1:0] == 2'h0)
            |=> (cap_q[DATA_W-1:0] == $past(hwdata));
    endproperty
    a_cap_write: assert property (p_cap_write) // R10
        else $error("capacity chunk not stored");

    property p_id_hold;
        @(posedge ref_clk) disable iff (por_rst)
        (id_locked_q && !del_fire) |=> $stable(id_q);
    endproperty
    a_id_hold: assert property (p_id_hold) // R13
        else $error("locked unique id changed");

    property p_org_read;
        @(posedge ref_clk) disable iff (rst)
        (ce && rd_pend_q && hit_org)
            |=> (hrdata_q == {ORG_PAD, $past(id_q[ID_ORG_LSB +: ID_ORG_W])});
    endproperty
    a_org_read: assert property (p_org_read) // R14
        else $error("organization id read wrong");

    property p_rsvd_read;
        @(posedge ref_clk) disable iff (rst)
        (ce && rd_pend_q && hit_rsvd) |=> (hrdata_q == WORD_ZERO);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) // R15
        else $error("reserved word read nonzero");

    property p_read_wait;
        @(posedge ref_clk) disable iff (rst)
        (ce && addr_ok && !hwrite) |=> (!hreadyout_q && rd_pend_q);
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state missing");

endmodule // ns_ident_regs

//--- dv/tb_ns_ident_regs.sv
module tb_ns_ident_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ns_ident_pkg::*;

    localparam int LIMIT = 20000;

    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        por_rst = 1'b1;
    logic        ce      = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = WORD_ZERO;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = WORD_ZERO;
    logic        mgmt    = 1'b1;
    logic [15:0] ctrl_u [3] = '{16'h0004, 16'h0008, 16'h000C};
    logic [31:0] id_w [4]   = '{32'h0123_4567, 32'h89AB_CDEF, 32'h00C0_FFEE, 32'h7654_3210};
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic        hresp_q;
    int          fail_count = 0;
    int          compares   = 0;
    int          cycles     = 0;

    ns_ident_regs uut (
        .ref_clk                        (ref_clk),
        .rst                            (rst),
        .por_rst                        (por_rst),
        .ce                             (ce),
        .hsel                           (hsel),
        .haddr                          (haddr),
        .htrans                         (htrans),
        .hwrite                         (hwrite),
        .hsize                          (hsize),
        .hwdata                         (hwdata),
        .hready                         (hreadyout_q),
        .hrdata_q                       (hrdata_q),
        .hreadyout_q                    (hreadyout_q),
        .hresp_q                        (hresp_q),
        .ctrl_normal_atomic_unit        (ctrl_u[0]),
        .ctrl_powerfail_atomic_unit     (ctrl_u[1]),
        .ctrl_compare_write_atomic_unit (ctrl_u[2]),
        .ns_mgmt_supported              (mgmt)
    );

    // free-running 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ba(input logic [7:0] idx);
        ba = {22'h0, idx, 2'h0};
    endfunction

    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd_v);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout_q !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        if (wr) begin
            hwdata <= wd;
        end
        do @(posedge ref_clk); while (hreadyout_q !== 1'b1);
        rd_v = hrdata_q;
        check({31'h0, hresp_q}, {31'h0, HRESP_OKAY});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, WORD_ZERO, v);
        check(v, exp);
    endtask

    // main sequence
    initial begin
        logic [15:0] bt [6][4];
        bt = '{'{16'h8, 16'h10, 16'h5, 16'h5}, '{16'h8, 16'h10, 16'hC, 16'h8},
               '{16'h10, 16'h8, 16'hC, 16'h8}, '{16'h0, 16'h0, 16'h7, 16'h0},
               '{16'h8, 16'h0, 16'h3, 16'h0}, '{16'h8, 16'h10, 16'h8, 16'h8}};
        repeat (6) @(posedge ref_clk);
        rst     <= 1'b0;
        por_rst <= 1'b0;
        @(posedge ref_clk);
        // identify fields 0x22-0x6B read zero after power-up, reserved and unmapped too; status reads 0xA
        for (int a = 32'h088; a <= 32'h1AC; a += 4) rd(a, WORD_ZERO);
        rd(32'h0000_0300, WORD_ZERO);
        rd(ba(IDX_PROV_STATUS), 32'hA);
        // locked fields ignore writes until unlocked
        wr(ba(IDX_NS_NORMAL_ATOMIC_UNIT), 32'h55);
        rd(ba(IDX_NS_NORMAL_ATOMIC_UNIT), WORD_ZERO);
        wr(ba(IDX_PROV_CTRL), 32'h1);
        // atomic units: own value, then zero once equal to controller
        for (int k = 0; k < 3; k++) begin
            wr(ba(IDX_NS_NORMAL_ATOMIC_UNIT) + 8 * k, 32'hFFFF_0021 + k);
            rd(ba(IDX_NS_NORMAL_ATOMIC_UNIT) + 8 * k, 32'h21 + k);
            ctrl_u[k] <= 16'h0021 + 16'(k);
            rd(ba(IDX_NS_NORMAL_ATOMIC_UNIT) + 8 * k, WORD_ZERO);
        end
        // boundary sizes and clamped offset
        for (int k = 0; k < 6; k++) begin
            wr(ba(IDX_NS_NORMAL_BOUNDARY_SIZE), {16'h0, bt[k][0]});
            wr(ba(IDX_NS_POWERFAIL_BOUNDARY_SIZE), {16'h0, bt[k][1]});
            wr(ba(IDX_NS_BOUNDARY_START_OFFSET), {16'h0, bt[k][2]});
            rd(ba(IDX_NS_NORMAL_BOUNDARY_SIZE), {16'h0, bt[k][0]});
            rd(ba(IDX_NS_POWERFAIL_BOUNDARY_SIZE), {16'h0, bt[k][1]});
            rd(ba(IDX_NS_BOUNDARY_START_OFFSET), {16'h0, bt[k][3]});
        end
        // capacity, four little-endian words
        for (int k = 0; k < 4; k++) wr(ba(IDX_NS_ALLOCATED_CAPACITY) + 4 * k, 32'hA500_0000 + k);
        for (int k = 0; k < 4; k++) rd(ba(IDX_NS_ALLOCATED_CAPACITY) + 4 * k, 32'hA500_0000 + k);
        rd(ba(IDX_PROV_STATUS), 32'h6);
        mgmt <= 1'b0;
        rd(ba(IDX_PROV_STATUS), 32'h4);
        mgmt <= 1'b1;
        // reserved stays zero even when written
        wr(ba(IDX_RESERVED_A), 32'hFFFF_FFFF);
        wr(ba(IDX_RESERVED_B), 32'hFFFF_FFFF);
        rd(ba(IDX_RESERVED_A), WORD_ZERO);
        rd(ba(IDX_RESERVED_B), WORD_ZERO);
        // unique id, organization slice, then lock
        for (int k = 0; k < 4; k++) wr(ba(IDX_NS_GLOBAL_UNIQUE_ID) + 4 * k, id_w[k]);
        for (int k = 0; k < 4; k++) rd(ba(IDX_NS_GLOBAL_UNIQUE_ID) + 4 * k, id_w[k]);
        rd(ba(IDX_ID_ORG), {ORG_PAD, id_w[2][23:0]});
        wr(ba(IDX_PROV_CTRL), 32'h3);
        rd(ba(IDX_PROV_STATUS), 32'h7);
        wr(ba(IDX_NS_GLOBAL_UNIQUE_ID), 32'hDEAD_BEEF);
        rd(ba(IDX_NS_GLOBAL_UNIQUE_ID), id_w[0]);
        // controller reset keeps the id and lock, clears the rest
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int k = 0; k < 4; k++) rd(ba(IDX_NS_GLOBAL_UNIQUE_ID) + 4 * k, id_w[k]);
        rd(ba(IDX_NS_ALLOCATED_CAPACITY), WORD_ZERO);
        rd(ba(IDX_PROV_STATUS), 32'hB);
        // delete releases the id
        wr(ba(IDX_PROV_CTRL), 32'h5);
        rd(ba(IDX_NS_GLOBAL_UNIQUE_ID) + 4, WORD_ZERO);
        rd(ba(IDX_PROV_STATUS), 32'hA);
        stop_test();
    end

endmodule // tb_ns_ident_regs
